//--- rtl/bcr_params.svh
`ifndef BCR_PARAMS_SVH
`define BCR_PARAMS_SVH

// Timing in own units
`define BCR_CLK_HZ           20000000
`define BCR_CAPTURE_DELAY_MS 10
`define BCR_SETTLE_MIN_MS    3
`define BCR_SETTLE_MAX_MS    12
`define BCR_CAPTURE_CYC      (`BCR_CLK_HZ / 1000 * `BCR_CAPTURE_DELAY_MS)
`define BCR_SETTLE_MAX_CYC   (`BCR_CLK_HZ / 1000 * `BCR_SETTLE_MAX_MS)

// Reached status ignored this long after a target change, covers sync lag
`define BCR_REACH_BLANK_CYC  32'h8

// Target code, millivolts: top value and step
`define BCR_TARGET_TOP_MV    11'h6ac
`define BCR_TARGET_STEP_MV   11'h010

// Switching period in clocks, 250 kHz to 1 MHz per phase
`define BCR_PERIOD_MIN       8'h14
`define BCR_PERIOD_MAX       8'h50
`define BCR_PERIOD_DEF       8'h28

`endif

//--- rtl/bcr_pkg.sv
package bcr_pkg;
  typedef enum logic [1:0] {
    BCR_MODE_ACTIVE,
    BCR_MODE_DEEP,
    BCR_MODE_DEEPER
  } bcr_mode_e;

  typedef enum {
    BCR_ST_OFF,
    BCR_ST_BOOT,
    BCR_ST_WAIT,
    BCR_ST_RUN,
    BCR_ST_FAULT
  } bcr_state_e;

  typedef struct packed {
    logic high_side;
    logic low_side;
    logic drive_oe_n;
  } bcr_gate_s;

  typedef struct packed {
    logic under_volt;
    logic over_curr;
    logic over_volt;
  } bcr_fault_s;
endpackage : bcr_pkg

//--- rtl/bcr_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "bcr_params.svh"

module bcr_sequencer #(
  parameter int unsigned CAPTURE_CYC = `BCR_CAPTURE_CYC,
  parameter int unsigned SETTLE_CYC  = `BCR_SETTLE_MAX_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 system_regulator_on_i,
  input  wire logic                 power_ok_line_i,
  input  wire logic                 boot_in_window_i,
  input  wire logic                 target_reached_i,
  input  wire logic                 output_in_limits_i,
  input  wire logic                 channel_count_sel_i,
  input  wire logic                 stop_clock_n_i,
  input  wire logic                 deeper_sleep_request_i,
  input  wire logic [5:0]           voltage_code_i,
  input  wire logic [7:0]           frequency_set_i,
  input  wire bcr_pkg::bcr_fault_s  fault_i,
  output logic                      power_ok_line_o,
  output logic                      power_ok_line_oe_n_o,
  output bcr_pkg::bcr_gate_s        gate_ch1_o,
  output bcr_pkg::bcr_gate_s        gate_ch2_o,
  output logic                      boot_setpoint_sel_o,
  output logic                      fast_ramp_source_en_o,
  output logic [10:0]               code_target_voltage_o,
  output bcr_pkg::bcr_mode_e        mode_o,
  output logic                      settle_timeout_o
);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic [10:0] code_to_mv(input logic [5:0] code);
    code_to_mv = `BCR_TARGET_TOP_MV - 11'(code) * `BCR_TARGET_STEP_MV;
  endfunction : code_to_mv

  function automatic logic [7:0] clamp_period(input logic [7:0] p);
    if (p < `BCR_PERIOD_MIN) begin
      clamp_period = `BCR_PERIOD_MIN;
    end else if (p > `BCR_PERIOD_MAX) begin
      clamp_period = `BCR_PERIOD_MAX;
    end else begin
      clamp_period = p;
    end
  endfunction : clamp_period

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] sync_en, sync_pg, sync_ch, sync_stp, sync_drs, sync_bw, sync_tr, sync_il;
  logic [5:0] sync_code_a, sync_code_b, sync_code_c;
  logic       en, pg_in, two_ch, stp_n, drs, boot_ok, tgt_ok, in_lim;
  logic       next_en, next_pg_in, next_two_ch, next_stp_n, next_drs;
  logic       next_boot_ok, next_tgt_ok, next_in_lim;
  logic [5:0] code, next_code;

  always_comb begin
    next_en      = (sync_en[1] == sync_en[2]) ? sync_en[2] : en;
    next_pg_in   = (sync_pg[1] == sync_pg[2]) ? sync_pg[2] : pg_in;
    next_two_ch  = (sync_ch[1] == sync_ch[2]) ? sync_ch[2] : two_ch;
    next_stp_n   = (sync_stp[1] == sync_stp[2]) ? sync_stp[2] : stp_n;
    next_drs     = (sync_drs[1] == sync_drs[2]) ? sync_drs[2] : drs;
    next_boot_ok = (sync_bw[1] == sync_bw[2]) ? sync_bw[2] : boot_ok;
    next_tgt_ok  = (sync_tr[1] == sync_tr[2]) ? sync_tr[2] : tgt_ok;
    next_in_lim  = (sync_il[1] == sync_il[2]) ? sync_il[2] : in_lim;
    next_code    = (sync_code_b == sync_code_c) ? sync_code_c : code;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_en     <= 3'h0;
      sync_pg     <= 3'h0;
      sync_ch     <= 3'h0;
      sync_stp    <= 3'h7;
      sync_drs    <= 3'h0;
      sync_bw     <= 3'h0;
      sync_tr     <= 3'h0;
      sync_il     <= 3'h0;
      sync_code_a <= 6'h00;
      sync_code_b <= 6'h00;
      sync_code_c <= 6'h00;
      en          <= 1'h0;
      pg_in       <= 1'h0;
      two_ch      <= 1'h0;
      stp_n       <= 1'h1;
      drs         <= 1'h0;
      boot_ok     <= 1'h0;
      tgt_ok      <= 1'h0;
      in_lim      <= 1'h0;
      code        <= 6'h00;
    end else begin
      sync_en     <= {sync_en[1:0], system_regulator_on_i};
      sync_pg     <= {sync_pg[1:0], power_ok_line_i};
      sync_ch     <= {sync_ch[1:0], channel_count_sel_i};
      sync_stp    <= {sync_stp[1:0], stop_clock_n_i};
      sync_drs    <= {sync_drs[1:0], deeper_sleep_request_i};
      sync_bw     <= {sync_bw[1:0], boot_in_window_i};
      sync_tr     <= {sync_tr[1:0], target_reached_i};
      sync_il     <= {sync_il[1:0], output_in_limits_i};
      sync_code_a <= voltage_code_i;
      sync_code_b <= sync_code_a;
      sync_code_c <= sync_code_b;
      en          <= next_en;
      pg_in       <= next_pg_in;
      two_ch      <= next_two_ch;
      stp_n       <= next_stp_n;
      drs         <= next_drs;
      boot_ok     <= next_boot_ok;
      tgt_ok      <= next_tgt_ok;
      in_lim      <= next_in_lim;
      code        <= next_code;
    end
  end

  // ------------------------------------------------------------
  // Sequencer and fault latches
  // ------------------------------------------------------------
  bcr_pkg::bcr_state_e state, next_state;
  logic        uv_oc_latch, ov_latch, next_uv_oc_latch, next_ov_latch;
  logic [31:0] timer, next_timer;
  logic [5:0]  held_code, next_held_code;
  logic        moving, next_moving, fast, next_fast, tmo, next_tmo;
  logic        any_fault;

  assign any_fault = uv_oc_latch | ov_latch;

  always_comb begin
    next_state       = state;
    next_timer       = timer;
    next_held_code   = held_code;
    next_moving      = moving;
    next_fast        = fast;
    next_tmo         = tmo;
    next_ov_latch    = ov_latch | fault_i.over_volt;
    next_uv_oc_latch = (uv_oc_latch & en) | fault_i.under_volt | fault_i.over_curr;
    case (state)
      bcr_pkg::BCR_ST_OFF: begin
        next_fast = 1'b0;
        if (en && !ov_latch && !uv_oc_latch) begin
          next_state = bcr_pkg::BCR_ST_BOOT;
        end
      end
      bcr_pkg::BCR_ST_BOOT: begin
        next_timer = 32'h0;
        if (pg_in && boot_ok) begin
          next_state = bcr_pkg::BCR_ST_WAIT;
        end
      end
      bcr_pkg::BCR_ST_WAIT: begin
        next_timer = timer + 32'h1;
        if (timer >= CAPTURE_CYC - 1) begin
          next_held_code = code;
          next_fast      = 1'b1;
          next_moving    = 1'b1;
          next_timer     = 32'h0;
          next_state     = bcr_pkg::BCR_ST_RUN;
        end
      end
      bcr_pkg::BCR_ST_RUN: begin
        if (code != held_code) begin
          next_held_code = code;
          next_moving    = 1'b1;
          next_timer     = 32'h0;
        end else if (moving) begin
          next_timer = timer + 32'h1;
          if (tgt_ok && timer >= `BCR_REACH_BLANK_CYC) begin
            next_moving = 1'b0;
          end else if (timer >= SETTLE_CYC - 1) begin
            next_moving = 1'b0;
            next_tmo    = 1'b1;
          end
        end
      end
      bcr_pkg::BCR_ST_FAULT: begin
        if (!any_fault) begin
          next_state = bcr_pkg::BCR_ST_OFF;
        end
      end
      default: next_state = bcr_pkg::BCR_ST_OFF;
    endcase
    if (next_ov_latch || next_uv_oc_latch) begin
      next_state  = bcr_pkg::BCR_ST_FAULT;
      next_moving = 1'b0;
    end else if (!en && state != bcr_pkg::BCR_ST_FAULT) begin
      next_state  = bcr_pkg::BCR_ST_OFF;
      next_moving = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state       <= bcr_pkg::BCR_ST_OFF;
      uv_oc_latch <= 1'b0;
      ov_latch    <= 1'b0;
      timer       <= 32'h0;
      held_code   <= 6'h00;
      moving      <= 1'b0;
      fast        <= 1'b0;
      tmo         <= 1'b0;
    end else begin
      state       <= next_state;
      uv_oc_latch <= next_uv_oc_latch;
      ov_latch    <= next_ov_latch;
      timer       <= next_timer;
      held_code   <= next_held_code;
      moving      <= next_moving;
      fast        <= next_fast;
      tmo         <= next_tmo;
    end
  end

  // ------------------------------------------------------------
  // Phase generator and outputs
  // ------------------------------------------------------------
  logic [7:0] phase_cnt, next_phase_cnt, period;
  logic       running;
  bcr_pkg::bcr_gate_s next_g1, next_g2;
  bcr_pkg::bcr_mode_e next_mode;
  logic       next_pok, next_pok_oe_n, next_boot_sel;

  assign period  = clamp_period(frequency_set_i);
  assign running = (state == bcr_pkg::BCR_ST_BOOT || state == bcr_pkg::BCR_ST_WAIT ||
                    state == bcr_pkg::BCR_ST_RUN) && !any_fault;

  always_comb begin
    next_phase_cnt = (phase_cnt >= period - 8'h1) ? 8'h00 : phase_cnt + 8'h1;
    next_g1 = '{high_side: 1'b0, low_side: 1'b0, drive_oe_n: 1'b1};
    next_g2 = next_g1;
    if (running) begin
      next_g1 = '{high_side: (phase_cnt < (period >> 1)),
                  low_side: (phase_cnt >= (period >> 1)), drive_oe_n: 1'b0};
      if (two_ch) begin
        next_g2 = '{high_side: (phase_cnt >= (period >> 1)),
                    low_side: (phase_cnt < (period >> 1)), drive_oe_n: 1'b0};
      end
    end
    if (drs) begin
      next_mode = bcr_pkg::BCR_MODE_DEEPER;
    end else if (!stp_n) begin
      next_mode = bcr_pkg::BCR_MODE_DEEP;
    end else begin
      next_mode = bcr_pkg::BCR_MODE_ACTIVE;
    end
    next_boot_sel = (state != bcr_pkg::BCR_ST_RUN);
    next_pok      = 1'b0;
    next_pok_oe_n = 1'b1;
    if (any_fault) begin
      next_pok_oe_n = 1'b0;
    end else if (state == bcr_pkg::BCR_ST_RUN && !moving) begin
      next_pok_oe_n = in_lim;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_cnt             <= 8'h00;
      gate_ch1_o            <= '{high_side: 1'b0, low_side: 1'b0, drive_oe_n: 1'b1};
      gate_ch2_o            <= '{high_side: 1'b0, low_side: 1'b0, drive_oe_n: 1'b1};
      mode_o                <= bcr_pkg::BCR_MODE_ACTIVE;
      boot_setpoint_sel_o   <= 1'b1;
      fast_ramp_source_en_o <= 1'b0;
      code_target_voltage_o <= `BCR_TARGET_TOP_MV;
      power_ok_line_o       <= 1'b0;
      power_ok_line_oe_n_o  <= 1'b1;
      settle_timeout_o      <= 1'b0;
    end else begin
      phase_cnt             <= next_phase_cnt;
      gate_ch1_o            <= next_g1;
      gate_ch2_o            <= next_g2;
      mode_o                <= next_mode;
      boot_setpoint_sel_o   <= next_boot_sel;
      fast_ramp_source_en_o <= fast;
      code_target_voltage_o <= code_to_mv(held_code);
      power_ok_line_o       <= next_pok;
      power_ok_line_oe_n_o  <= next_pok_oe_n;
      settle_timeout_o      <= tmo;
    end
  end

endmodule : bcr_sequencer
`default_nettype wire

//--- verif/bcr_partner.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Companion regulators and output stage
// ------------------------------
module bcr_partner #(
  parameter int DELAY = 10
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        comp_a_i,
  input  wire logic        comp_b_i,
  input  wire logic        stall_i,
  input  wire logic        pg_oe_n_i,
  input  wire logic        gate_oe_n_i,
  input  wire logic [10:0] target_i,
  output logic             pg_line_o,
  output logic             win_o,
  output logic             reached_o,
  output logic             in_lim_o
);
  logic [10:0] last;
  int          cnt;
  assign pg_line_o = comp_a_i & comp_b_i & pg_oe_n_i;
  assign in_lim_o  = reached_o;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last      <= 11'h6ac;
      cnt       <= 0;
      win_o     <= 1'b0;
      reached_o <= 1'b1;
    end else begin
      win_o     <= !gate_oe_n_i;
      reached_o <= (target_i == last) && (cnt == 0);
      if (target_i != last) begin
        last <= target_i;
        cnt  <= DELAY;
      end else if (cnt > 0 && !stall_i) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : bcr_partner
`default_nettype wire

//--- verif/bcr_sequencer_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Sequencer checks
// ------------------------------
module bcr_sequencer_chk #(
  parameter int unsigned CAPTURE_CYC = 20,
  parameter int unsigned SETTLE_CYC  = 50
) (
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  input wire logic                deeper_sleep_request_i,
  input wire bcr_pkg::bcr_fault_s fault_i,
  input wire logic                power_ok_line_oe_n_o,
  input wire bcr_pkg::bcr_gate_s  gate_ch1_o,
  input wire bcr_pkg::bcr_gate_s  gate_ch2_o,
  input wire logic                boot_setpoint_sel_o,
  input wire logic                fast_ramp_source_en_o,
  input wire logic [10:0]         code_target_voltage_o,
  input wire bcr_pkg::bcr_mode_e  mode_o,
  input wire logic                settle_timeout_o
);
  logic [1:0] ov_age;
  logic [1:0] next_ov_age;
  logic       drv1;
  logic       drv2;
  assign drv1 = !gate_ch1_o.drive_oe_n;
  assign drv2 = !gate_ch2_o.drive_oe_n;
  always_comb begin
    next_ov_age = ov_age;
    if (fault_i.over_volt) begin
      next_ov_age = 2'h1;
    end else if (ov_age != 2'h0 && ov_age != 2'h3) begin
      next_ov_age = ov_age + 2'h1;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ov_age <= 2'h0;
    end else begin
      ov_age <= next_ov_age;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  float_quiet_a: assert property ((!drv1 |-> gate_ch1_o[2:1] == 2'h0) and
    (!drv2 |-> gate_ch2_o[2:1] == 2'h0)) else $error("floating drive has a switch on");
  fault_float_a: assert property (|fault_i |-> ##[1:2] (!drv1 && !drv2))
    else $error("drives not floated after fault");
  fault_pg_a: assert property (|fault_i && drv1 |-> ##[1:2] !power_ok_line_oe_n_o)
    else $error("power ok not pulled low after fault");
  ov_hold_a: assert property (ov_age == 2'h3 |-> !drv1 && !drv2)
    else $error("drives active after overvoltage");
  ramp_fast_a: assert property ($fell(boot_setpoint_sel_o) |-> fast_ramp_source_en_o)
    else $error("fast source off after boot");
  boot_leave_a: assert property ($rose(fast_ramp_source_en_o) |->
    ##[0:1] !boot_setpoint_sel_o) else $error("fast source during boot");
  boot_release_a: assert property (boot_setpoint_sel_o && !fast_ramp_source_en_o &&
    drv1 && !(|{fault_i, $past(fault_i), $past(fault_i, 2)}) |-> power_ok_line_oe_n_o)
    else $error("power ok line pulled during boot");
  phase_split_a: assert property (drv1 && drv2 |->
    gate_ch1_o.high_side != gate_ch2_o.high_side) else $error("channels not interleaved");
  timeout_sticky_a: assert property ($rose(settle_timeout_o) |=> settle_timeout_o [*8])
    else $error("settle timeout not sticky");
  target_step_a: assert property ($changed(code_target_voltage_o) |->
    code_target_voltage_o[3:0] == 4'hc && code_target_voltage_o >= 11'h2bc)
    else $error("target off the step grid");
  mode_deeper_a: assert property (deeper_sleep_request_i [*7] |->
    mode_o == bcr_pkg::BCR_MODE_DEEPER) else $error("deeper sleep not reported");
  cover property ($fell(boot_setpoint_sel_o));
  cover property (drv1 && drv2);
  cover property ($rose(settle_timeout_o));
endmodule : bcr_sequencer_chk
bind bcr_sequencer bcr_sequencer_chk #(.CAPTURE_CYC(CAPTURE_CYC), .SETTLE_CYC(SETTLE_CYC)) u_chk (
  .clk_i, .rst_n_i, .deeper_sleep_request_i, .fault_i, .power_ok_line_oe_n_o, .gate_ch1_o,
  .gate_ch2_o, .boot_setpoint_sel_o, .fast_ramp_source_en_o, .code_target_voltage_o, .mode_o,
  .settle_timeout_o);
`default_nettype wire

//--- verif/bcr_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// Sequencer testbench
// ------------------------------
module bcr_sequencer_tb;
  logic clk_i, rst_n_i, system_regulator_on_i, power_ok_line_i, boot_in_window_i;
  logic target_reached_i, output_in_limits_i, channel_count_sel_i, stop_clock_n_i;
  logic deeper_sleep_request_i, power_ok_line_o, power_ok_line_oe_n_o, boot_setpoint_sel_o;
  logic fast_ramp_source_en_o, settle_timeout_o, comp_a, comp_b, stall;
  logic [5:0]  voltage_code_i;
  logic [7:0]  frequency_set_i;
  logic [10:0] code_target_voltage_o, expv;
  bcr_pkg::bcr_fault_s fault_i;
  bcr_pkg::bcr_gate_s  gate_ch1_o, gate_ch2_o;
  bcr_pkg::bcr_mode_e  mode_o;
  int miscompares, checks, n, h1, h2, opp;
  logic [5:0] codes [4] = '{6'h00, 6'h01, 6'h3f, 6'h15};
  logic [2:0] flt [2] = '{3'h4, 3'h2};
  bcr_sequencer #(.CAPTURE_CYC(20), .SETTLE_CYC(50)) u_dut (.clk_i, .rst_n_i,
    .system_regulator_on_i, .power_ok_line_i, .boot_in_window_i, .target_reached_i,
    .output_in_limits_i, .channel_count_sel_i, .stop_clock_n_i, .deeper_sleep_request_i,
    .voltage_code_i, .frequency_set_i, .fault_i, .power_ok_line_o, .power_ok_line_oe_n_o,
    .gate_ch1_o, .gate_ch2_o, .boot_setpoint_sel_o, .fast_ramp_source_en_o,
    .code_target_voltage_o, .mode_o, .settle_timeout_o);
  bcr_partner u_far (.clk_i, .rst_n_i, .comp_a_i(comp_a), .comp_b_i(comp_b), .stall_i(stall),
    .pg_oe_n_i(power_ok_line_oe_n_o), .gate_oe_n_i(gate_ch1_o.drive_oe_n),
    .target_i(code_target_voltage_o), .pg_line_o(power_ok_line_i), .win_o(boot_in_window_i),
    .reached_o(target_reached_i), .in_lim_o(output_in_limits_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : cyc
  function automatic logic hit(input int sel);
    case (sel)
      0: return gate_ch1_o.drive_oe_n === 1'b0;
      2: return power_ok_line_oe_n_o === 1'b1;
      3: return settle_timeout_o === 1'b1;
      default: return code_target_voltage_o === expv;
    endcase
  endfunction : hit
  task automatic wait_sel(input int sel, input int lim);
    n = 0;
    checks++;
    while (!hit(sel)) begin
      cyc(1);
      n++;
      if (n > lim) begin
        miscompares++;
        $display("BAD %0t wait %0d", $time, sel);
        results();
      end
    end
  endtask : wait_sel
  task automatic count(input int len);
    h1 = 0;
    h2 = 0;
    opp = 0;
    repeat (len) begin
      cyc(1);
      h1 += int'(gate_ch1_o.high_side === 1'b1);
      h2 += int'(gate_ch2_o.high_side === 1'b1);
      opp += int'(gate_ch1_o.high_side !== gate_ch2_o.high_side);
    end
  endtask : count
  task automatic supply_cycle;
    @(posedge clk_i) rst_n_i <= 1'b0;
    cyc(2);
    chk({gate_ch1_o, gate_ch2_o}, 11'h009, "reset float");
    @(posedge clk_i) rst_n_i <= 1'b1;
    wait_sel(0, 12);
  endtask : supply_cycle
  function automatic logic [10:0] mv(input logic [5:0] c);
    return 11'h6ac - {1'b0, c, 4'h0};
  endfunction : mv
  initial begin
    {rst_n_i, deeper_sleep_request_i, comp_a, comp_b, stall} = 5'h00;
    {system_regulator_on_i, channel_count_sel_i, stop_clock_n_i} = 3'h7;
    voltage_code_i = 6'h2a;
    frequency_set_i = 8'h14;
    fault_i = 3'h0;
    miscompares = 0;
    checks = 0;
    cyc(12);
    chk({gate_ch1_o, gate_ch2_o}, 11'h009, "float in reset");
    chk(code_target_voltage_o, 11'h6ac, "reset target");
    @(posedge clk_i) rst_n_i <= 1'b1;
    wait_sel(0, 12);
    chk({boot_setpoint_sel_o, fast_ramp_source_en_o, power_ok_line_oe_n_o}, 11'h5,
      "boot");
    @(posedge clk_i) comp_a <= 1'b1;
    cyc(40);
    chk(boot_setpoint_sel_o, 1'b1, "held at boot");
    @(posedge clk_i) comp_b <= 1'b1;
    expv = mv(6'h2a);
    wait_sel(4, 60);
    chk(n > 19, 1'b1, "capture delay");
    cyc(2);
    chk({boot_setpoint_sel_o, fast_ramp_source_en_o}, 11'h1, "run ramp");
    count(40);
    chk(11'(h1 + h2 + opp), 11'd80, "phase split");
    foreach (codes[i]) begin
      wait_sel(2, 80);
      @(posedge clk_i) voltage_code_i <= codes[i];
      expv = mv(codes[i]);
      wait_sel(4, 12);
      cyc(8);
      chk({power_ok_line_o, power_ok_line_oe_n_o}, 11'h1, "masked");
    end
    @(posedge clk_i) stall <= 1'b1;
    voltage_code_i <= 6'h2b;
    wait_sel(3, 120);
    @(posedge clk_i) stall <= 1'b0;
    cyc(40);
    chk(settle_timeout_o, 1'b1, "timeout sticky");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i) {stop_clock_n_i, deeper_sleep_request_i} <= 2'(i);
      channel_count_sel_i <= i[1];
      cyc(25);
      count(40);
      chk(mode_o, i[0] ? 2'(bcr_pkg::BCR_MODE_DEEPER) : i[1] ? 2'(bcr_pkg::BCR_MODE_ACTIVE)
        : 2'(bcr_pkg::BCR_MODE_DEEP), "mode");
      chk(11'(h2), i[1] ? 11'd20 : 11'd0, "channel count");
    end
    @(posedge clk_i) deeper_sleep_request_i <= 1'b0;
    frequency_set_i <= 8'h50;
    cyc(160);
    count(160);
    chk(11'(h1 + h2), 11'd160, "slow period");
    foreach (flt[i]) begin
      @(posedge clk_i) fault_i <= flt[i];
      @(posedge clk_i) fault_i <= 3'h0;
      cyc(15);
      chk({gate_ch1_o, gate_ch2_o, power_ok_line_oe_n_o}, 11'h012, "tripped");
      @(posedge clk_i) system_regulator_on_i <= 1'b0;
      cyc(8);
      @(posedge clk_i) system_regulator_on_i <= 1'b1;
      wait_sel(0, 12);
    end
    @(posedge clk_i) fault_i <= 3'h1;
    @(posedge clk_i) fault_i <= 3'h0;
    cyc(4);
    @(posedge clk_i) system_regulator_on_i <= 1'b0;
    cyc(8);
    @(posedge clk_i) system_regulator_on_i <= 1'b1;
    cyc(20);
    chk(gate_ch1_o, 11'h001, "overvoltage held");
    supply_cycle();
    cyc(30);
    supply_cycle();
    results();
  end
endmodule : bcr_sequencer_tb
`default_nettype wire
